// ===== astx_consts.svh
// Constants for the asynchronous serial transmitter: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef ASTX_CONSTS_SVH
`define ASTX_CONSTS_SVH

// Register indices on the plain register port (4-bit address).
`define ASTX_ADDR_BAUD_CONTROL     4'h0
`define ASTX_ADDR_INTERRUPT_CTRL   4'h1
`define ASTX_ADDR_PERIPH_IRQ_EN1   4'h2
`define ASTX_ADDR_PERIPH_IRQ_FLG1  4'h3
`define ASTX_ADDR_RECV_STAT_CTRL   4'h4
`define ASTX_ADDR_BAUD_DIV_LOW     4'h5
`define ASTX_ADDR_BAUD_DIV_HIGH    4'h6
`define ASTX_ADDR_TX_HOLD_BUF      4'h7
`define ASTX_ADDR_TX_STAT_CTRL     4'h8

// Field positions.
`define ASTX_BIT_WIDE_DIV          3
`define ASTX_BIT_GLOBAL_IE         7
`define ASTX_BIT_PERIPH_IE         6
`define ASTX_BIT_TX_IRQ_EN         4
`define ASTX_BIT_TX_FLAG           4
`define ASTX_BIT_PORT_EN           7
`define ASTX_BIT_NINE_SEL          6
`define ASTX_BIT_TX_EN             5
`define ASTX_BIT_SYNC_MODE         4
`define ASTX_BIT_HIGH_SPEED        2
`define ASTX_BIT_SHIFT_EMPTY       1
`define ASTX_BIT_NINTH_DATA        0

// Reset values.
`define ASTX_RESET_BYTE            8'h00
`define ASTX_TXSTAT_RESET          8'h02

// Timing: clock period in ns and one instruction cycle (four clocks).
`define ASTX_CLK_PERIOD_NS         20
`define ASTX_TCY_NS                80
`define ASTX_TCY_CLKS              ((`ASTX_TCY_NS + `ASTX_CLK_PERIOD_NS - 1) / `ASTX_CLK_PERIOD_NS)
// Flag update settles within two instruction cycles of a buffer write.
`define ASTX_FLAG_SETTLE_CLKS      (2 * `ASTX_TCY_CLKS)
// Frame bits: start + up to nine data + stop.
`define ASTX_FRAME_BITS_8          10
`define ASTX_FRAME_BITS_9          11

`endif

// ===== astx_pkg.sv
// Types shared by the asynchronous serial transmitter.
// Assumes the constants header is on the include path.
`include "astx_consts.svh"
package astx_pkg;
   // Transmitter sequencing states, one-hot.
   typedef enum logic [2:0] {
      ASTX_IDLE  = 3'b001,
      ASTX_SHIFT = 3'b010,
      ASTX_GAP   = 3'b100
   } astx_state_e;

   // Plain register port request.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } astx_req_s;
endpackage : astx_pkg

// ===== astx_transmitter.sv
// Asynchronous serial transmitter with holding buffer, shifter and baud divider.
// Assumes a 50 MHz clock, synchronous active-high reset and a one-cycle register port.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "astx_consts.svh"

// ************************************************************
// Overview of operation.
// ************************************************************
// Software fills the one-deep holding buffer through the register port.
// When the shifter is idle, a written character goes straight into the
// frame shift register in the same cycle. Otherwise it waits in the
// holding buffer until the stop bit of the current frame has gone out.
//
// After every frame the sequencer spends one instruction cycle in a gap
// state with the line high. A queued character is loaded at the end of
// that gap. The gap is the only spacing between back-to-back frames.
//
// The frame register holds the start bit, the data bits, the optional
// ninth bit and the stop bit. It shifts right, so bit 0 drives the line
// while shifting. Ones are shifted in from the top, so a late tick can only ever
// put the idle level on the line and never a false start bit.
//
// The baud generator runs only while a frame is being shifted. Between
// frames it is preloaded with a full period, so that every bit, the start
// bit included, lasts the programmed number of clocks.
//
// The buffer empty flag is a registered copy of the buffer state. It
// trails a buffer write by two clocks, well inside the two instruction
// cycles that software must wait before trusting it.
//
// Limitations that a user must know:
// - Receiver, break, auto-baud and synchronous modes are not present;
//   their control bits are stored, but only the sync mode bit has an effect here.
// - The sync mode bit only blocks transmission; it does not turn the
//   serial pin into a clock.
// - Clearing the port enable or transmit enable mid-frame cuts the frame
//   short. A remote receiver sees a broken character, which is the price
//   of making the disable take effect at once.
// - A buffer write while the transmitter is disabled is dropped.
// - Control bits that change while a frame is in flight take effect for
//   the next frame only where they are sampled at load time; the baud
//   divisor, however, is read on every tick.
//
// Register map, one byte per index on the plain register port:
//   0 baud control, 1 interrupt control, 2 peripheral irq enables,
//   3 peripheral irq flags, 4 receive status and control,
//   5 and 6 baud divisor low and high, 7 holding buffer (write only),
//   8 transmit status and control.

module astx_transmitter
   import astx_pkg::*;
(
   input  wire logic       i_clk,          // System clock, 50 MHz.
   input  wire logic       i_reset,        // Synchronous reset, active high.
   input  wire astx_req_s  i_req,          // Register port request.
   output logic      [7:0] o_rdata,        // Read data, cycle after the read strobe.
   output logic            o_tx_out,       // Serial output pin level.
   output logic            o_tx_oe,        // Serial output pin enable.
   output logic            o_irq           // Transmit interrupt request.
);

   // ************************************************************
   // Registers written by software.
   // ************************************************************
   logic [7:0] baud_ctrl_q;     // Baud control byte.
   logic [7:0] int_ctrl_q;      // Global and peripheral enables.
   logic [7:0] peripheral_irq_enable_1_q;          // Peripheral interrupt enables.
   logic [7:0] receive_status_control_q;         // Receive status/control (port enable here).
   logic [7:0] div_lo_q;        // Baud divisor low.
   logic [7:0] div_hi_q;        // Baud divisor high.
   logic [7:0] transmit_status_control_q;         // Transmit control, writable bits only.
   logic [7:0] rdata_q;         // Registered read data.

   // Decoded writes.
   wire wr_bc  = i_req.wr && (i_req.addr == `ASTX_ADDR_BAUD_CONTROL);
   wire wr_ic  = i_req.wr && (i_req.addr == `ASTX_ADDR_INTERRUPT_CTRL);
   wire wr_pie = i_req.wr && (i_req.addr == `ASTX_ADDR_PERIPH_IRQ_EN1);
   wire wr_rc  = i_req.wr && (i_req.addr == `ASTX_ADDR_RECV_STAT_CTRL);
   wire wr_lo  = i_req.wr && (i_req.addr == `ASTX_ADDR_BAUD_DIV_LOW);
   wire wr_hi  = i_req.wr && (i_req.addr == `ASTX_ADDR_BAUD_DIV_HIGH);
   wire wr_buf = i_req.wr && (i_req.addr == `ASTX_ADDR_TX_HOLD_BUF);
   wire wr_ts  = i_req.wr && (i_req.addr == `ASTX_ADDR_TX_STAT_CTRL);

   // Control bits.
   wire port_en   = receive_status_control_q[`ASTX_BIT_PORT_EN];
   wire tx_en     = transmit_status_control_q[`ASTX_BIT_TX_EN];
   wire sync_mode = transmit_status_control_q[`ASTX_BIT_SYNC_MODE];
   wire nine_sel  = transmit_status_control_q[`ASTX_BIT_NINE_SEL];
   wire ninth_bit = transmit_status_control_q[`ASTX_BIT_NINTH_DATA];
   wire wide_div  = baud_ctrl_q[`ASTX_BIT_WIDE_DIV];
   wire high_spd  = transmit_status_control_q[`ASTX_BIT_HIGH_SPEED];
   wire active    = tx_en && !sync_mode && port_en;

   // Control register write process; the flag bit in the flags register is not stored,
   // so a software write can neither set nor clear it.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         baud_ctrl_q <= `ASTX_RESET_BYTE;
         int_ctrl_q  <= `ASTX_RESET_BYTE;
         peripheral_irq_enable_1_q      <= `ASTX_RESET_BYTE;
         receive_status_control_q     <= `ASTX_RESET_BYTE;
         div_lo_q    <= `ASTX_RESET_BYTE;
         div_hi_q    <= `ASTX_RESET_BYTE;
         transmit_status_control_q     <= `ASTX_RESET_BYTE;
      end else begin
         if (wr_bc)  baud_ctrl_q <= i_req.wdata;
         if (wr_ic)  int_ctrl_q  <= i_req.wdata;
         if (wr_pie) peripheral_irq_enable_1_q      <= i_req.wdata;
         if (wr_rc)  receive_status_control_q     <= i_req.wdata;
         if (wr_lo)  div_lo_q    <= i_req.wdata;
         if (wr_hi)  div_hi_q    <= i_req.wdata;
         // Status bit position is masked off; it is hardware-owned.
         if (wr_ts)  transmit_status_control_q     <= i_req.wdata & 8'hFD;
      end
   end

   // ************************************************************
   // Baud rate generator.
   // ************************************************************
   // Divisor is 8-bit or 16-bit; the prescale of 16, 4 or 1 follows the
   // high-speed and wide-divisor selections. Bit period = prescale*(div+1).
   wire [15:0] divisor = wide_div ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
   wire [5:0]  prescale = (wide_div && high_spd) ? 6'h01 :
                          (wide_div || high_spd) ? 6'h04 : 6'h10;
   logic [15:0] div_cnt_q;      // Counts down divisor reloads.
   logic [5:0]  pre_cnt_q;      // Counts prescale clocks.
   wire pre_tick  = (pre_cnt_q == 6'h00);
   wire baud_tick = pre_tick && (div_cnt_q == 16'h0000);

   // The generator is held in restart whenever the shifter is not sending so
   // that the first bit of a frame gets a full period.
   logic shifting;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pre_cnt_q <= 6'h00;
         div_cnt_q <= 16'h0000;
      end else if (!shifting) begin
         // Preload a full period; a zero here would cut the start bit to one clock.
         pre_cnt_q <= prescale - 6'h01;
         div_cnt_q <= divisor;
      end else if (pre_tick) begin
         pre_cnt_q <= prescale - 6'h01;
         div_cnt_q <= baud_tick ? divisor : div_cnt_q - 16'h0001;
      end else begin
         pre_cnt_q <= pre_cnt_q - 6'h01;
      end
   end

   // ************************************************************
   // Holding buffer and shifter sequencing.
   // ************************************************************
   astx_state_e state_q;        // Sequencer state.
   logic [8:0]  hold_q;         // Holding buffer with captured ninth bit.
   logic        hold_full_q;    // A character waits in the holding buffer.
   logic [10:0] shreg_q;        // Frame shift register, not software visible.
   logic [3:0]  bits_left_q;    // Bits remaining in the frame.
   logic [1:0]  gap_cnt_q;      // One instruction cycle after stop.

   assign shifting = (state_q == ASTX_SHIFT);
   wire   idle_ld  = (state_q == ASTX_IDLE);
   wire   last_bit = shifting && baud_tick && (bits_left_q == 4'h1);
   wire   gap_done = (state_q == ASTX_GAP) && (gap_cnt_q == 2'h0);
   // A written character goes straight in when idle; else queued.
   wire   load_now = active && wr_buf && idle_ld && !hold_full_q;
   wire   load_q   = active && hold_full_q && (idle_ld || gap_done);
   wire   load     = load_now || load_q;
   // Character captured with the ninth bit stored at write time.
   wire [8:0] wchar = {ninth_bit, i_req.wdata};
   wire [8:0] lchar = load_now ? wchar : hold_q;
   // Frame: stop, [ninth], data LSB first, start (low).
   wire [10:0] frame = nine_sel ? {1'b1, lchar, 1'b0} :
                                  {2'b11, lchar[7:0], 1'b0};
   // In nine-bit mode the ninth bit goes out just before the stop bit, so a
   // one there marks the character as an address for a listening receiver.

   // Sequencer process.
   always_ff @(posedge i_clk) begin
      if (i_reset || !active) begin
         // Disabling aborts the frame and drops the queued character.
         state_q     <= ASTX_IDLE;
         hold_full_q <= 1'b0;
         shreg_q     <= 11'h7FF;
         bits_left_q <= 4'h0;
         gap_cnt_q   <= 2'h0;
         hold_q      <= 9'h000;
      end else begin
         if (wr_buf && !load_now) begin
            hold_q      <= wchar;
            hold_full_q <= 1'b1;
         end else if (load_q) begin
            hold_full_q <= 1'b0;
         end
         case (state_q)
            ASTX_IDLE: begin
               if (load) begin
                  state_q     <= ASTX_SHIFT;
                  shreg_q     <= frame;
                  bits_left_q <= nine_sel ? 4'(`ASTX_FRAME_BITS_9)
                                          : 4'(`ASTX_FRAME_BITS_8);
               end
            end
            ASTX_SHIFT: begin
               if (baud_tick) begin
                  shreg_q     <= {1'b1, shreg_q[10:1]};
                  bits_left_q <= bits_left_q - 4'h1;
                  if (last_bit) begin
                     state_q   <= ASTX_GAP;
                     gap_cnt_q <= 2'(`ASTX_TCY_CLKS - 1);
                  end
               end
            end
            ASTX_GAP: begin
               if (gap_done) begin
                  if (load) begin
                     state_q     <= ASTX_SHIFT;
                     shreg_q     <= frame;
                     bits_left_q <= nine_sel ? 4'(`ASTX_FRAME_BITS_9)
                                             : 4'(`ASTX_FRAME_BITS_8);
                  end else begin
                     state_q <= ASTX_IDLE;
                  end
               end else begin
                  gap_cnt_q <= gap_cnt_q - 2'h1;
               end
            end
            default: state_q <= ASTX_IDLE;
         endcase
      end
   end

   // The flag is a registered copy of the buffer state. It lags a buffer
   // write by two clocks, inside the two instruction cycles allowed for it.
   // It is never written by software, so no write path reaches it.
   logic tx_flag_q;             // Published buffer empty flag.
   always_ff @(posedge i_clk) begin
      if (i_reset) tx_flag_q <= 1'b0;
      else tx_flag_q <= active && !hold_full_q;
   end

   // ************************************************************
   // Outputs and read path.
   // ************************************************************
   wire shift_empty = !shifting;
   assign o_tx_out = shifting ? shreg_q[0] : 1'b1;
   assign o_tx_oe  = port_en;
   // Only the buffer flag and its enables form the request.
   assign o_irq = tx_flag_q && peripheral_irq_enable_1_q[`ASTX_BIT_TX_IRQ_EN] &&
                  int_ctrl_q[`ASTX_BIT_GLOBAL_IE] &&
                  int_ctrl_q[`ASTX_BIT_PERIPH_IE];

   // Read multiplexer; holding buffer and shifter read as zero.
   wire [7:0] flags_rd = {3'b000, tx_flag_q, 4'h0};
   wire [7:0] txs_rd   = transmit_status_control_q | {6'h00, shift_empty, 1'b0};
   wire [7:0] rd_mux =
      (i_req.addr == `ASTX_ADDR_BAUD_CONTROL)    ? baud_ctrl_q :
      (i_req.addr == `ASTX_ADDR_INTERRUPT_CTRL)  ? int_ctrl_q  :
      (i_req.addr == `ASTX_ADDR_PERIPH_IRQ_EN1)  ? peripheral_irq_enable_1_q      :
      (i_req.addr == `ASTX_ADDR_PERIPH_IRQ_FLG1) ? flags_rd    :
      (i_req.addr == `ASTX_ADDR_RECV_STAT_CTRL)  ? receive_status_control_q     :
      (i_req.addr == `ASTX_ADDR_BAUD_DIV_LOW)    ? div_lo_q    :
      (i_req.addr == `ASTX_ADDR_BAUD_DIV_HIGH)   ? div_hi_q    :
      (i_req.addr == `ASTX_ADDR_TX_STAT_CTRL)    ? txs_rd      : 8'h00;

   // Read data is registered and stands only in the cycle after the strobe.
   always_ff @(posedge i_clk) begin
      if (i_reset) rdata_q <= 8'h00;
      else rdata_q <= i_req.rd ? rd_mux : 8'h00;
   end
   assign o_rdata = rdata_q;

   // ************************************************************
   // Assertions.
   // ************************************************************
   sequence load_seq;
      idle_ld && load;
   endsequence
   idle_high_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !shifting |-> o_tx_out) else $error("line not idle high");
   start_low_a: assert property (@(posedge i_clk) disable iff (i_reset)
      load_seq |=> (shifting && !o_tx_out)) else $error("no start bit");
   inactive_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !active |=> !shifting) else $error("sent while disabled");
   oe_port_a: assert property (@(posedge i_clk) disable iff (i_reset)
      o_tx_oe == port_en) else $error("pin enable wrong");
   flag_en_a: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(active) && !hold_full_q |=> tx_flag_q) else $error("flag not set");

   // A write while a frame is in flight must show as a full buffer by the
   // second clock, even if the gap ends and drains the buffer meanwhile.
   flag_settle_a: assert property (@(posedge i_clk) disable iff (i_reset)
      wr_buf && active && !idle_ld |-> ##2 !tx_flag_q)
      else $error("flag stale");

   // The gap after a frame lasts exactly one instruction cycle.
   gap_len_a: assert property (@(posedge i_clk) disable iff (i_reset || !active)
      last_bit |=> (state_q == ASTX_GAP) [*4] ##1 (state_q != ASTX_GAP))
      else $error("gap length wrong");

   // Every tick inside a frame moves the next higher bit onto the line.
   lsb_first_a: assert property (@(posedge i_clk) disable iff (i_reset || !active)
      shifting && baud_tick && !last_bit |=> o_tx_out == $past(shreg_q[1]))
      else $error("bit order wrong");

   // The final bit of every frame is the stop bit, high.
   stop_high_a: assert property (@(posedge i_clk) disable iff (i_reset)
      last_bit |-> o_tx_out) else $error("stop bit low");

   // No frame may start while the transmitter is disabled.
   no_load_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !active |-> !load) else $error("load while disabled");

   // A character waiting behind a busy shifter clears the flag.
   flag_full_a: assert property (@(posedge i_clk) disable iff (i_reset)
      hold_full_q && active |=> !tx_flag_q) else $error("flag set while full");

   irq_src_a: assert property (@(posedge i_clk) disable iff (i_reset)
      o_irq |-> tx_flag_q) else $error("irq without flag");
   empty_st_a: assert property (@(posedge i_clk) disable iff (i_reset)
      load |=> !shift_empty) else $error("status not cleared");
endmodule : astx_transmitter
`default_nettype wire

// ===== astx_line_rx.sv
// Behavioural model of the remote receiver that listens on the serial line.
// Assumes the line shares the system clock and a fixed bit period in clocks.
`timescale 1ns/10ps
`default_nettype none

module astx_line_rx #(
   parameter int BIT_CLKS = 4            // Clocks per bit on the line.
) (
   input  wire logic       i_clk,        // Sampling clock.
   input  wire logic       i_line,       // Serial line level.
   input  wire logic       i_nine,       // Expect nine data bits.
   output logic      [8:0] o_data,       // Last character received.
   output logic            o_valid,      // One-cycle pulse per character.
   output logic            o_addr,       // Character is marked as an address.
   output logic            o_stop_ok     // Stop bit was seen high.
);
   logic [8:0] bits;                     // First bit on the line lands in bit 0.
   int         nbits;                    // Data bits in the current frame.

   initial begin
      o_data    = '0;
      o_valid   = 1'b0;
      o_addr    = 1'b0;
      o_stop_ok = 1'b0;
   end

   // Sample each data bit and the stop bit at its middle, so a wrong bit period shows as bad data.
   always begin
      @(negedge i_line);
      repeat (BIT_CLKS / 2) @(posedge i_clk);
      nbits = i_nine ? 9 : 8;
      bits  = '0;
      for (int k = 0; k < nbits; k++) begin
         repeat (BIT_CLKS) @(posedge i_clk);
         bits[k] = i_line;
      end
      repeat (BIT_CLKS) @(posedge i_clk);
      o_stop_ok = i_line;
      o_data    = bits;
      o_addr    = i_nine & bits[8];
      o_valid   = 1'b1;
      @(posedge i_clk);
      o_valid   = 1'b0;
   end
endmodule : astx_line_rx

`default_nettype wire

// ===== astx_transmitter_tb.sv
// Self-checking testbench for the asynchronous serial transmitter.
// Assumes the design package, the constants header and the line receiver model.
`timescale 1ns/10ps
`default_nettype none
`include "astx_consts.svh"

module astx_transmitter_tb;
   import astx_pkg::*;
   localparam int BITC = 4;        // Prescale 1 and divisor 3 give four clocks a bit.
   logic       clk;                // System clock.
   logic       rst;                // Synchronous reset.
   logic       nine_mode;          // Tells the receiver the frame length.
   astx_req_s  req;                // Register port request.
   logic [7:0] rdata;              // Register read data.
   logic       tx;                 // Serial line.
   logic       oe;                 // Serial pin enable.
   logic       irq;                // Interrupt request.
   logic [8:0] rx_data;            // Character seen by the receiver.
   logic       rx_valid;           // Receiver strobe.
   logic       rx_addr;            // Receiver address mark.
   logic       rx_stop;            // Receiver stop level.
   int         failures;           // Mismatches.
   int         checked;            // Comparisons.

   astx_transmitter dut_u (.i_clk(clk), .i_reset(rst), .i_req(req), .o_rdata(rdata),
                           .o_tx_out(tx), .o_tx_oe(oe), .o_irq(irq));
   astx_line_rx #(.BIT_CLKS(BITC)) rx_u (.i_clk(clk), .i_line(tx), .i_nine(nine_mode),
                           .o_data(rx_data), .o_valid(rx_valid), .o_addr(rx_addr),
                           .o_stop_ok(rx_stop));

   // ************************************************
   // Helpers
   // ************************************************
   task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One-cycle write; the strobe drops one edge later, so calls never collide.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe.
   task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(nm, {1'b0, exp}, {1'b0, rdata});
   endtask : rchk

   // Bounded wait for the receiver, then compare the character and stop bit.
   task automatic get_char(input logic [8:0] exp);
      int n = 0;
      while (rx_valid !== 1'b1 && n < 800) begin
         @(negedge clk);
         n++;
      end
      chk("char arrived", 9'h001, {8'h00, rx_valid});
      chk("line char", exp, rx_data);
      chk("stop bit", 9'h001, {8'h00, rx_stop});
      @(negedge clk);
   endtask : get_char

   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_reset;
      rchk("tx status", `ASTX_ADDR_TX_STAT_CTRL, 8'h02);
      rchk("flags", `ASTX_ADDR_PERIPH_IRQ_FLG1, 8'h00);
      rchk("hold buf read", `ASTX_ADDR_TX_HOLD_BUF, 8'h00);
      rchk("unmapped", 4'hF, 8'h00);
      chk("pin enable", 9'h000, {8'h00, oe});
      chk("idle line", 9'h001, {8'h00, tx});
   endtask : t_reset

   // Sync mode set: a buffer write must not start a frame.
   task automatic t_sync;
      wr(`ASTX_ADDR_BAUD_CONTROL, 8'h08);
      wr(`ASTX_ADDR_BAUD_DIV_LOW, 8'h03);
      wr(`ASTX_ADDR_BAUD_DIV_HIGH, 8'h00);
      wr(`ASTX_ADDR_RECV_STAT_CTRL, 8'h80);
      #1;
      chk("pin enable", 9'h001, {8'h00, oe});
      wr(`ASTX_ADDR_TX_STAT_CTRL, 8'h34);
      wr(`ASTX_ADDR_TX_HOLD_BUF, 8'h55);
      repeat (3 * BITC) @(negedge clk);
      chk("sync line", 9'h001, {8'h00, tx});
      rchk("sync status", `ASTX_ADDR_TX_STAT_CTRL, 8'h36);
   endtask : t_sync

   task automatic t_flag_irq;
      wr(`ASTX_ADDR_TX_STAT_CTRL, 8'h24);
      rchk("flag on enable", `ASTX_ADDR_PERIPH_IRQ_FLG1, 8'h10);
      wr(`ASTX_ADDR_PERIPH_IRQ_FLG1, 8'h00);
      rchk("flag write", `ASTX_ADDR_PERIPH_IRQ_FLG1, 8'h10);
      wr(`ASTX_ADDR_PERIPH_IRQ_EN1, 8'h10);
      #1;
      chk("irq no global", 9'h000, {8'h00, irq});
      wr(`ASTX_ADDR_INTERRUPT_CTRL, 8'hC0);
      #1;
      chk("irq all set", 9'h001, {8'h00, irq});
      wr(`ASTX_ADDR_PERIPH_IRQ_EN1, 8'h00);
      #1;
      chk("irq masked", 9'h000, {8'h00, irq});
      rchk("flag masked", `ASTX_ADDR_PERIPH_IRQ_FLG1, 8'h10);
   endtask : t_flag_irq

   task automatic t_single;
      wr(`ASTX_ADDR_TX_HOLD_BUF, 8'hA5);
      repeat (2) @(negedge clk);
      chk("start at once", 9'h000, {8'h00, tx});
      rchk("shifter busy", `ASTX_ADDR_TX_STAT_CTRL, 8'h24);
      chk("no status irq", 9'h000, {8'h00, irq});
      get_char(9'h0A5);
      repeat (2 * BITC) @(negedge clk);
      rchk("shifter empty", `ASTX_ADDR_TX_STAT_CTRL, 8'h26);
   endtask : t_single

   task automatic t_back2back;
      wr(`ASTX_ADDR_TX_HOLD_BUF, 8'h3C);
      wr(`ASTX_ADDR_TX_HOLD_BUF, 8'hC3);
      repeat (8) @(posedge clk);
      rchk("flag queued", `ASTX_ADDR_PERIPH_IRQ_FLG1, 8'h00);
      get_char(9'h03C);
      get_char(9'h0C3);
      rchk("flag drained", `ASTX_ADDR_PERIPH_IRQ_FLG1, 8'h10);
   endtask : t_back2back

   task automatic t_nine;
      nine_mode = 1'b1;
      wr(`ASTX_ADDR_TX_STAT_CTRL, 8'h65);
      wr(`ASTX_ADDR_TX_HOLD_BUF, 8'h42);
      get_char(9'h142);
      chk("address mark", 9'h001, {8'h00, rx_addr});
      wr(`ASTX_ADDR_TX_STAT_CTRL, 8'h64);
      wr(`ASTX_ADDR_TX_HOLD_BUF, 8'h81);
      get_char(9'h081);
      nine_mode = 1'b0;
   endtask : t_nine

   // Port disabled in mid-frame with a character queued behind it.
   task automatic t_abort;
      logic low_seen = 1'b0;
      wr(`ASTX_ADDR_TX_STAT_CTRL, 8'h24);
      wr(`ASTX_ADDR_TX_HOLD_BUF, 8'h00);
      wr(`ASTX_ADDR_TX_HOLD_BUF, 8'h00);
      repeat (3 * BITC) @(negedge clk);
      wr(`ASTX_ADDR_RECV_STAT_CTRL, 8'h00);
      repeat (2) @(negedge clk);
      chk("abort line", 9'h001, {8'h00, tx});
      chk("abort pin", 9'h000, {8'h00, oe});
      rchk("abort status", `ASTX_ADDR_TX_STAT_CTRL, 8'h26);
      wr(`ASTX_ADDR_RECV_STAT_CTRL, 8'h80);
      repeat (25 * BITC) begin
         @(negedge clk);
         if (tx !== 1'b1) low_seen = 1'b1;
      end
      chk("queue dropped", 9'h000, {8'h00, low_seen});
   endtask : t_abort

   // ************************************************
   // Verdict, clock, reset and sequence
   // ************************************************
   task automatic results;
      $display("Comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // The whole run needs a few hundred cycles; 20000 means a hang.
   initial begin
      #(20 * 20000);
      failures++;
      results();
   end

   initial begin
      rst       = 1'b1;
      nine_mode = 1'b0;
      req       = '0;
      failures  = 0;
      checked   = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_sync();
      t_flag_irq();
      t_single();
      t_back2back();
      t_nine();
      t_abort();
      results();
   end
endmodule : astx_transmitter_tb

`default_nettype wire
